//--- design/dmsd_decode.sv
// Data-space decoder: SPECIAL_FUNCTION_REGISTER, scratchpad, on-chip SRAM and external bus
// Operation
// - Economy mode divides clock by 4/64/1024
// - Idle stops core clock, peripherals run
// - Power-down stops every internal clock
// - Halt bit stops all, idle bit core
// - On-chip SRAM answers only when enabled
// - Reset clears enable; all goes external
// - Enabled SRAM covers 0000H to 03FFH
// - Addresses above 03FFH always go external
// - Instruction fetches never reach on-chip SRAM
// - 256-byte scratchpad, direct and indirect
// - SFRs at 80h-FFh, direct access only
// - Bit access only at x0/x8 addresses
// - Unimplemented SPECIAL_FUNCTION_REGISTER bits read as one
// - Program space up to 64 KB
// - External data space up to 64 KB
// - Port 0 multiplexes low address, data
// - Stack pointer holds scratchpad top address
// - Data pointer low is pointer bits 7:0
`include "dmsd_map.svh"
module dmsd_decode (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wake,
  input wire logic intReq,
  input wire logic intWe,
  input wire logic intIndirect,
  input wire logic intBitOp,
  input wire logic [2:0] intBitSel,
  input wire logic [7:0] intAddr,
  input wire logic [7:0] intWdata,
  output logic [7:0] intRdata_q,
  output logic intAck_q,
  input wire logic xReq,
  input wire logic xWe,
  input wire logic xUseDptr,
  input wire logic [7:0] xAddrHigh,
  input wire logic [7:0] xAddrLow,
  input wire logic [7:0] xWdata,
  output logic [7:0] xRdata_q,
  output logic xDone_q,
  input wire logic codeReq,
  input wire logic [15:0] codeAddr,
  input wire logic [7:0] p0In,
  output logic [7:0] p0Out_q,
  output logic [7:0] p0Oe_q,
  output logic [7:0] p2Out_q,
  output logic ale_q,
  output logic rdN_q,
  output logic wrN_q,
  output logic psenN_q,
  output logic [7:0] stackTop_q,
  output logic [7:0] dptrLow_q,
  output logic cpuClkEn_q,
  output logic periphClkEn_q
);
  typedef struct packed {
    dmsd_pkg::dmsd_xstate_t xst;
    dmsd_pkg::dmsd_sfr_t special_function_register;
    dmsd_pkg::dmsd_bus_t bus;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic fetch;
    logic [7:0] xRdata;
    logic xDone;
    logic [7:0] intRdata;
    logic intAck;
  } dmsd_state_t;

  dmsd_state_t st_q, st_d;
  // Neither array is reset; contents stay undefined until written
  logic [7:0] sram [`DMSD_SRAM_WORDS];
  logic [7:0] scratch [`DMSD_SCRATCH_WORDS];
  logic cpuRun, runAll, intTake, sfrHit, xTake, codeTake, xHit;
  logic [15:0] xAddr;

  // Read view of the SPECIAL_FUNCTION_REGISTER space, missing bits and rows read high
  // unimplemented reads high
  function automatic logic [7:0] sfrRead(input dmsd_pkg::dmsd_sfr_t s, input logic [7:0] a);
    case (a)
      `DMSD_SFR_P0: sfrRead = s.p0Latch;
      `DMSD_SFR_SP: sfrRead = s.sp;
      `DMSD_SFR_DPL: sfrRead = s.data_pointer_low_byte;
      `DMSD_SFR_PCON: sfrRead = s.pcon | ~`DMSD_PCON_IMPL;
      `DMSD_SFR_PMR: sfrRead = s.power_management_reg | ~`DMSD_PMR_IMPL;
      default: sfrRead = `DMSD_UNIMPL;
    endcase
  endfunction

  // On-chip SRAM claims the address only when enabled and in range
  function automatic logic onchipHit(input logic en, input logic [15:0] a);
    onchipHit = en && (a <= `DMSD_SRAM_TOP);
  endfunction

  dmsd_clk_ctl u_clk (
    .core_clk(core_clk),
    .rst(rst),
    .haltAll(st_q.special_function_register.pcon[`DMSD_PCON_PD]),
    .cpuStop(st_q.special_function_register.pcon[`DMSD_PCON_IDL]),
    .divSel(st_q.special_function_register.power_management_reg[`DMSD_PMR_DIV_HI:`DMSD_PMR_DIV_LO]),
    .cpuClkEn_q(cpuClkEn_q),
    .periphClkEn_q(periphClkEn_q)
  );

  // Request acceptance and address decode
  always_comb begin
    // core requests only on core clock
    cpuRun = cpuClkEn_q;
    runAll = periphClkEn_q;
    intTake = intReq && cpuRun;
    // upper half direct goes to SFRs
    sfrHit = !intIndirect && intAddr[`DMSD_SFR_SPACE];
    xAddr = xUseDptr ? {xAddrHigh, st_q.special_function_register.data_pointer_low_byte} : {xAddrHigh, xAddrLow};
    xTake = xReq && cpuRun && (st_q.xst == dmsd_pkg::XS_IDLE);
    codeTake = codeReq && !xReq && cpuRun && (st_q.xst == dmsd_pkg::XS_IDLE);
    // enable bit gates the on-chip SRAM
    xHit = onchipHit(st_q.special_function_register.power_management_reg[`DMSD_PMR_DME], xAddr);
  end

  // Next state: registers, internal reads and the external bus cycle
  always_comb begin
    logic [7:0] wv;
    wv = '0;
    st_d = st_q;
    st_d.xDone = 1'b0;
    st_d.intAck = 1'b0;
    // Wake clears both mode bits; a PCON write in the same cycle wins
    if (wake) begin
      st_d.special_function_register.pcon[`DMSD_PCON_PD] = 1'b0;
      st_d.special_function_register.pcon[`DMSD_PCON_IDL] = 1'b0;
    end
    if (intTake) begin
      st_d.intAck = 1'b1;
      if (sfrHit) begin
        wv = sfrRead(st_q.special_function_register, intAddr);
        wv[intBitSel] = intWdata[0];
        if (!intBitOp) begin
          wv = intWdata;
        end
        st_d.intRdata = sfrRead(st_q.special_function_register, intAddr);
        if (intWe && (!intBitOp || intAddr[2:0] == `DMSD_BIT_ROW)) begin
          case (intAddr)
            `DMSD_SFR_P0: st_d.special_function_register.p0Latch = wv;
            `DMSD_SFR_SP: st_d.special_function_register.sp = wv;
            `DMSD_SFR_DPL: st_d.special_function_register.data_pointer_low_byte = wv;
            `DMSD_SFR_PCON: st_d.special_function_register.pcon = wv & `DMSD_PCON_IMPL;
            `DMSD_SFR_PMR: st_d.special_function_register.power_management_reg = wv & `DMSD_PMR_IMPL;
            default: st_d.special_function_register = st_q.special_function_register;
          endcase
        end
      end else begin
        st_d.intRdata = scratch[intAddr];
      end
    end
    case (st_q.xst)
      dmsd_pkg::XS_IDLE: begin
        // Port 0 acts as open-drain latch outside bus cycles
        st_d.bus.p0Out = `DMSD_BYTE_ZERO;
        st_d.bus.p0Oe = ~st_q.special_function_register.p0Latch;
        if (xTake && xHit) begin
          st_d.xRdata = sram[xAddr[`DMSD_SRAM_AW-1:0]];
          st_d.xDone = 1'b1;
        end else if (xTake || codeTake) begin
          st_d.addr = xTake ? xAddr : codeAddr;
          st_d.we = xTake && xWe;
          st_d.fetch = !xTake;
          st_d.wdata = xWdata;
          st_d.xst = dmsd_pkg::XS_ADDR;
          st_d.bus.ale = 1'b1;
          st_d.bus.p0Out = st_d.addr[7:0];
          st_d.bus.p0Oe = `DMSD_BYTE_ONES;
          st_d.bus.p2Out = st_d.addr[15:8];
        end
      end
      dmsd_pkg::XS_ADDR: begin
        // Address and strobe phases advance only on peripheral clock enables; the done phase returns to idle on the next clock
        if (runAll) begin
          st_d.xst = dmsd_pkg::XS_STRB;
          st_d.bus.ale = 1'b0;
          st_d.bus.rdN = st_q.we || st_q.fetch;
          st_d.bus.wrN = !st_q.we;
          st_d.bus.psenN = !st_q.fetch;
          // data follows address on port 0
          st_d.bus.p0Out = st_q.wdata;
          st_d.bus.p0Oe = st_q.we ? `DMSD_BYTE_ONES : `DMSD_BYTE_ZERO;
        end
      end
      dmsd_pkg::XS_STRB: begin
        // Read data is taken on the edge that ends the strobe
        if (runAll) begin
          st_d.xst = dmsd_pkg::XS_DONE;
          st_d.xRdata = p0In;
          st_d.bus.rdN = 1'b1;
          st_d.bus.wrN = 1'b1;
          st_d.bus.psenN = 1'b1;
          st_d.bus.p0Oe = `DMSD_BYTE_ZERO;
        end
      end
      dmsd_pkg::XS_DONE: begin
        st_d.xst = dmsd_pkg::XS_IDLE;
        st_d.xDone = 1'b1;
      end
      default: st_d.xst = dmsd_pkg::XS_IDLE;
    endcase
  end

  // State register, reset clears the SRAM enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.xst <= dmsd_pkg::XS_IDLE;
      st_q.special_function_register.p0Latch <= `DMSD_RST_P0;
      st_q.special_function_register.sp <= `DMSD_RST_SP;
      st_q.special_function_register.data_pointer_low_byte <= `DMSD_RST_DPL;
      st_q.special_function_register.pcon <= `DMSD_RST_PCON;
      st_q.special_function_register.power_management_reg <= `DMSD_RST_PMR;
      st_q.bus.rdN <= 1'b1;
      st_q.bus.wrN <= 1'b1;
      st_q.bus.psenN <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Memory writes: on-chip SRAM by data moves, scratchpad by core
  always_ff @(posedge core_clk) begin
    if (xTake && xHit && xWe) begin
      sram[xAddr[`DMSD_SRAM_AW-1:0]] <= xWdata;
    end
    if (intTake && !sfrHit && intWe) begin
      scratch[intAddr] <= intWdata;
    end
  end

  // Outputs straight from state flops
  assign intRdata_q = st_q.intRdata;
  assign intAck_q = st_q.intAck;
  assign xRdata_q = st_q.xRdata;
  assign xDone_q = st_q.xDone;
  assign p0Out_q = st_q.bus.p0Out;
  assign p0Oe_q = st_q.bus.p0Oe;
  assign p2Out_q = st_q.bus.p2Out;
  assign ale_q = st_q.bus.ale;
  assign rdN_q = st_q.bus.rdN;
  assign wrN_q = st_q.bus.wrN;
  assign psenN_q = st_q.bus.psenN;
  assign stackTop_q = st_q.special_function_register.sp;
  assign dptrLow_q = st_q.special_function_register.data_pointer_low_byte;

  // Guards on decode, register access and bus sequencing
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_hit_no_bus: assert property (xTake && xHit |=> xDone_q && ale_q == 1'b0 ##1 ale_q == 1'b0)
    else $error("on-chip hit started a bus cycle");
  a_high_goes_ext: assert property (xTake && xAddr > `DMSD_SRAM_TOP |=> ale_q && !xDone_q)
    else $error("high address not sent external");
  a_disabled_ext: assert property (xTake && !st_q.special_function_register.power_management_reg[`DMSD_PMR_DME] |=> ale_q)
    else $error("disabled SRAM answered");
  a_reset_disable: assert property ($fell(rst) |-> !st_q.special_function_register.power_management_reg[`DMSD_PMR_DME])
    else $error("SRAM enabled after reset");
  a_fetch_external: assert property (codeTake |=> ale_q ##1 (!$past(runAll) || !psenN_q))
    else $error("fetch did not use program strobe");
  a_ale_low_addr: assert property (ale_q |-> p0Oe_q == `DMSD_BYTE_ONES && p0Out_q == st_q.addr[7:0])
    else $error("port 0 not carrying low address");
  a_unimpl_reads: assert property (intTake && sfrHit && !intWe && intAddr == 8'h83
    |=> intRdata_q == `DMSD_UNIMPL)
    else $error("unimplemented SPECIAL_FUNCTION_REGISTER not read high");
  a_bit_off_row: assert property (intTake && sfrHit && intWe && intBitOp && intAddr == `DMSD_SFR_SP
    |=> $stable(stackTop_q))
    else $error("bit write hit non-bit register");
  a_indirect_scratch: assert property (intTake && intIndirect && intWe && intAddr == `DMSD_SFR_SP
    |=> $stable(stackTop_q))
    else $error("indirect access reached an SPECIAL_FUNCTION_REGISTER");
  a_sp_write_lands: assert property (intTake && sfrHit && intWe && !intBitOp
    && intAddr == `DMSD_SFR_SP |=> stackTop_q == $past(intWdata))
    else $error("stack pointer write lost");
  a_dpl_write_lands: assert property (intTake && sfrHit && intWe && !intBitOp
    && intAddr == `DMSD_SFR_DPL |=> dptrLow_q == $past(intWdata))
    else $error("data pointer low write lost");
  a_fetch_no_sram: assert property (codeTake |=> !xDone_q)
    else $error("fetch answered without a bus cycle");
  a_one_data_strobe: assert property (rdN_q || wrN_q)
    else $error("read and write strobes both active");
endmodule // dmsd_decode

//--- design/dmsd_map.svh
// Address map, field positions, reset values and counts of the data-space decoder
`ifndef DMSD_MAP_SVH
`define DMSD_MAP_SVH
`define DMSD_SFR_P0 8'h80
`define DMSD_SFR_SP 8'h81
`define DMSD_SFR_DPL 8'h82
`define DMSD_SFR_PCON 8'h87
`define DMSD_SFR_PMR 8'hc4
`define DMSD_RST_P0 8'hff
`define DMSD_RST_SP 8'h07
`define DMSD_RST_DPL 8'h00
`define DMSD_RST_PCON 8'h00
`define DMSD_RST_PMR 8'h00
`define DMSD_PCON_IMPL 8'hcf
`define DMSD_PMR_IMPL 8'hc1
`define DMSD_UNIMPL 8'hff
`define DMSD_PCON_PD 1
`define DMSD_PCON_IDL 0
`define DMSD_PMR_DME 0
`define DMSD_PMR_DIV_HI 7
`define DMSD_PMR_DIV_LO 6
`define DMSD_BIT_ROW 3'h0
`define DMSD_SFR_SPACE 7
`define DMSD_SRAM_TOP 16'h03ff
`define DMSD_SRAM_AW 10
`define DMSD_SRAM_WORDS 1024
`define DMSD_SCRATCH_WORDS 256
`define DMSD_DIV_OFF 2'h0
`define DMSD_DIV_4 2'h1
`define DMSD_DIV_64 2'h2
`define DMSD_DIV_1024 2'h3
`define DMSD_LIM_4 10'h003
`define DMSD_LIM_64 10'h03f
`define DMSD_LIM_1024 10'h3ff
`define DMSD_CNT_ONE 10'h001
`define DMSD_BYTE_ONES 8'hff
`define DMSD_BYTE_ZERO 8'h00
`endif

//--- design/dmsd_pkg.sv
// Types shared by the data-space decoder and its clock control
package dmsd_pkg;
  typedef enum logic [3:0] {
    XS_IDLE = 4'h1,
    XS_ADDR = 4'h2,
    XS_STRB = 4'h4,
    XS_DONE = 4'h8
  } dmsd_xstate_t;

  typedef struct packed {
    logic [7:0] p0Latch;
    logic [7:0] sp;
    logic [7:0] data_pointer_low_byte;
    logic [7:0] pcon;
    logic [7:0] power_management_reg;
  } dmsd_sfr_t;

  typedef struct packed {
    logic [7:0] p0Out;
    logic [7:0] p0Oe;
    logic [7:0] p2Out;
    logic ale;
    logic rdN;
    logic wrN;
    logic psenN;
  } dmsd_bus_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic cpuEn;
    logic perEn;
  } dmsd_clk_t;
endpackage

//--- design/dmsd_clk_ctl.sv
// Economy divider and idle / power-down clock enables
`include "dmsd_map.svh"
module dmsd_clk_ctl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic haltAll,
  input wire logic cpuStop,
  input wire logic [1:0] divSel,
  output logic cpuClkEn_q,
  output logic periphClkEn_q
);
  dmsd_pkg::dmsd_clk_t st_q, st_d;

  // Terminal count for each economy ratio
  function automatic logic [9:0] divLimit(input logic [1:0] sel);
    case (sel)
      `DMSD_DIV_4: divLimit = `DMSD_LIM_4;
      `DMSD_DIV_64: divLimit = `DMSD_LIM_64;
      `DMSD_DIV_1024: divLimit = `DMSD_LIM_1024;
      default: divLimit = '0;
    endcase
  endfunction

  // Next divider count and enables
  always_comb begin
    logic tick;
    tick = 1'b0;
    st_d = st_q;
    tick = (divSel == `DMSD_DIV_OFF) || (st_q.cnt >= divLimit(divSel));
    if (haltAll) begin
      st_d.cnt = st_q.cnt; // Frozen, nothing runs
    end else if (tick) begin
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + `DMSD_CNT_ONE;
    end
    st_d.perEn = tick && !haltAll;
    st_d.cpuEn = tick && !haltAll && !cpuStop;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cpuClkEn_q = st_q.cpuEn;
  assign periphClkEn_q = st_q.perEn;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_idle_core_stop: assert property (cpuStop |=> !cpuClkEn_q)
    else $error("core clock ran while stopped");
  a_halt_all_stop: assert property (haltAll |=> !periphClkEn_q && !cpuClkEn_q)
    else $error("clock ran in power-down");
  a_div_four_gap: assert property ((periphClkEn_q && divSel == `DMSD_DIV_4 && !haltAll
    ##1 (divSel == `DMSD_DIV_4 && !haltAll)[*4]) |-> periphClkEn_q && !$past(periphClkEn_q))
    else $error("divide by four spacing wrong");
endmodule // dmsd_clk_ctl

//--- verification/dmsd_ext_mem.sv
// External program and data memory on the multiplexed port 0 / port 2 bus
module dmsd_ext_mem (
  input wire logic core_clk,
  input wire logic [7:0] p0Out,
  input wire logic [7:0] p0Oe,
  input wire logic [7:0] p2Out,
  input wire logic ale,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic psenN,
  output logic [7:0] p0In
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dataMem [0:65535];
  logic [15:0] addr;
  logic [7:0] lastLevel;
  logic [7:0] drive;
  // Preset the data space with a pattern the bench can predict
  initial begin
    for (int i = 0; i < 65536; i++) begin
      dataMem[i] = 8'(i) ^ 8'(i >> 8);
    end
    addr = 16'h0000;
    lastLevel = 8'h00;
  end
  // low address latched
  // Sampled while the latch strobe is still high, so data cannot race in
  always @(posedge core_clk) begin
    if (ale === 1'b1) addr <= {p2Out, p0In};
  end
  always @(posedge core_clk) begin
    if (wrN === 1'b0) dataMem[addr] <= p0In;
    lastLevel <= p0In;
  end
  always_comb begin
    if (psenN === 1'b0) drive = addr[7:0] + 8'h5a;
    else if (rdN === 1'b0) drive = dataMem[addr];
    else drive = ~lastLevel;
  end
  // Released bits show the inverse of the last level when no read or program strobe is active
  assign p0In = (p0Oe & p0Out) | (~p0Oe & drive);
endmodule // dmsd_ext_mem

//--- verification/data_memory_space_decode_test.sv
// Self-checking bench of the data-space decoder
module data_memory_space_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, wake, intReq, intWe, intIndirect, intBitOp, intAck_q;
  logic [2:0] intBitSel;
  logic [7:0] intAddr, intWdata, intRdata_q, xAddrHigh, xAddrLow, xWdata, xRdata_q, p0In;
  logic [7:0] p0Out_q, p0Oe_q, p2Out_q, stackTop_q, dptrLow_q, rd;
  logic xReq, xWe, xUseDptr, xDone_q, codeReq, ale_q, rdN_q, wrN_q, psenN_q;
  logic cpuClkEn_q, periphClkEn_q;
  logic [15:0] codeAddr;
  int mismatches = 0;
  int comparisons = 0;
  int busCycles = 0;
  int c, p;
  int div [4] = '{1, 4, 64, 1024};
  dmsd_decode dut (.core_clk, .rst, .wake, .intReq, .intWe, .intIndirect, .intBitOp,
    .intBitSel, .intAddr, .intWdata, .intRdata_q, .intAck_q, .xReq, .xWe, .xUseDptr,
    .xAddrHigh, .xAddrLow, .xWdata, .xRdata_q, .xDone_q, .codeReq, .codeAddr, .p0In,
    .p0Out_q, .p0Oe_q, .p2Out_q, .ale_q, .rdN_q, .wrN_q, .psenN_q, .stackTop_q,
    .dptrLow_q, .cpuClkEn_q, .periphClkEn_q);
  dmsd_ext_mem mem (.core_clk, .p0Out(p0Out_q), .p0Oe(p0Oe_q), .p2Out(p2Out_q),
    .ale(ale_q), .rdN(rdN_q), .wrN(wrN_q), .psenN(psenN_q), .p0In);
  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Counts cycles with any external strobe active
  always @(negedge core_clk) begin
    if (ale_q !== 1'b0 || rdN_q !== 1'b1 || wrN_q !== 1'b1 || psenN_q !== 1'b1) busCycles++;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("CHECK FAILED handshake expected answer seen none");
    final_report();
  endtask
  // Internal access: taken when the core clock is enabled, answered one cycle later
  task automatic intAcc(input logic we, ind, bop, input logic [2:0] bs, input logic [7:0] a, wd);
    int k;
    {intReq, intWe, intIndirect, intBitOp, intBitSel, intAddr, intWdata} = {1'b1, we, ind, bop, bs, a, wd};
    k = 0;
    while (cpuClkEn_q !== 1'b1) begin
      @(negedge core_clk);
      k++;
      if (k > 3000) timeout();
    end
    @(negedge core_clk);
    intReq = 1'b0;
    check("intAck_q", 1, intAck_q);
    rd = intRdata_q;
    @(negedge core_clk);
  endtask
  task automatic rdChk(input logic ind, input logic [7:0] a, exp);
    intAcc(1'b0, ind, 1'b0, 3'h0, a, 8'h00);
    check("intRdata_q", exp, rd);
  endtask
  // Data move or code read; checks latency and whether the bus was used
  task automatic xAcc(input logic we, dp, cd, input logic [15:0] a, input logic [7:0] wd,
                      input int cyc, input logic bus);
    int k, b;
    b = busCycles;
    {xReq, codeReq, xWe, xUseDptr, xAddrHigh, xAddrLow, codeAddr, xWdata} = {!cd, cd, we, dp, a, a, wd};
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
      if (k > 3000) timeout();
    end while (xDone_q !== 1'b1);
    {xReq, codeReq} = 2'b00;
    check("xfer cycles", cyc, k);
    check("bus used", bus, busCycles != b);
    rd = xRdata_q;
    @(negedge core_clk);
  endtask
  task automatic cnt(input int cyc);
    c = 0;
    p = 0;
    repeat (cyc) begin
      @(negedge core_clk);
      c += int'(cpuClkEn_q === 1'b1);
      p += int'(periphClkEn_q === 1'b1);
    end
  endtask
  task automatic t_reset();
    check("stackTop_q", 8'h07, stackTop_q);
    check("dptrLow_q", 8'h00, dptrLow_q);
    rdChk(1'b0, 8'h80, 8'hff);
    rdChk(1'b0, 8'hc4, 8'h3e);
    rdChk(1'b0, 8'h87, 8'h30);
    rdChk(1'b0, 8'h83, 8'hff);
    $display("test reset done");
  endtask
  task automatic t_sfr();
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'h81, 8'h55);
    check("stackTop_q", 8'h55, stackTop_q);
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'h82, 8'h34);
    check("dptrLow_q", 8'h34, dptrLow_q);
    intAcc(1'b1, 1'b1, 1'b0, 3'h0, 8'h81, 8'haa);
    rdChk(1'b1, 8'h81, 8'haa);
    rdChk(1'b0, 8'h81, 8'h55);
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'h20, 8'h66);
    rdChk(1'b1, 8'h20, 8'h66);
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'h90, 8'h00);
    rdChk(1'b0, 8'h90, 8'hff);
    intAcc(1'b1, 1'b0, 1'b1, 3'h3, 8'h80, 8'h00);
    rdChk(1'b0, 8'h80, 8'hf7);
    intAcc(1'b1, 1'b0, 1'b1, 3'h0, 8'h81, 8'h00);
    rdChk(1'b0, 8'h81, 8'h55);
    $display("test sfr done");
  endtask
  task automatic t_xmem();
    xAcc(1'b1, 1'b0, 1'b0, 16'h0010, 8'h77, 4, 1'b1);
    xAcc(1'b0, 1'b0, 1'b0, 16'h0010, 8'h00, 4, 1'b1);
    check("xRdata_q", 8'h77, rd);
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'hc4, 8'h01);
    xAcc(1'b1, 1'b0, 1'b0, 16'h0010, 8'h99, 1, 1'b0);
    xAcc(1'b1, 1'b0, 1'b0, 16'h03ff, 8'h3c, 1, 1'b0);
    xAcc(1'b0, 1'b0, 1'b0, 16'h0010, 8'h00, 1, 1'b0);
    check("xRdata_q", 8'h99, rd);
    xAcc(1'b0, 1'b0, 1'b0, 16'h03ff, 8'h00, 1, 1'b0);
    check("xRdata_q", 8'h3c, rd);
    xAcc(1'b0, 1'b0, 1'b0, 16'h0400, 8'h00, 4, 1'b1);
    check("xRdata_q", 8'h04, rd);
    xAcc(1'b0, 1'b0, 1'b1, 16'h0010, 8'h00, 4, 1'b1);
    check("code byte", 8'h6a, rd);
    xAcc(1'b0, 1'b1, 1'b0, 16'h12ff, 8'h00, 4, 1'b1);
    check("dptr read", 8'h26, rd);
    check("p2Out_q", 8'h12, p2Out_q);
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'hc4, 8'h00);
    xAcc(1'b0, 1'b0, 1'b0, 16'h0010, 8'h00, 4, 1'b1);
    check("xRdata_q", 8'h77, rd);
    $display("test data moves done");
  endtask
  task automatic t_clocks();
    for (int s = 1; s < 4; s++) begin
      intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'hc4, {2'(s), 6'h00});
      cnt(div[s] * 2);
      check("cpu pulses", 2, c);
      check("periph pulses", 2, p);
    end
    intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'hc4, 8'h00);
    for (int m = 1; m < 3; m++) begin
      intAcc(1'b1, 1'b0, 1'b0, 3'h0, 8'h87, 8'(m));
      cnt(20);
      check("cpu pulses", 0, c);
      check("periph pulses", (m == 1) ? 20 : 0, p);
      wake = 1'b1;
      @(negedge core_clk);
      wake = 1'b0;
      repeat (3) @(negedge core_clk);
      cnt(10);
      check("cpu after wake", 10, c);
    end
    $display("test clocks done");
  endtask
  // Main sequence
  initial begin
    {wake, intReq, intWe, intIndirect, intBitOp, intBitSel, intAddr, intWdata} = '0;
    {xReq, xWe, xUseDptr, xAddrHigh, xAddrLow, xWdata, codeReq, codeAddr} = '0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_sfr();
    t_xmem();
    t_clocks();
    final_report();
  end
endmodule // data_memory_space_decode_test
